/* File: hw/eps_pkg.sv */
// eps_pkg: register map, field positions and reset values of the
// pwm output stage; shared by the design and its bench.
package eps_pkg;
	localparam logic [2:0] OFS_CTRL   = 3'h0;
	localparam logic [2:0] OFS_DUTY   = 3'h1;
	localparam logic [2:0] OFS_SHUT   = 3'h2;
	localparam logic [2:0] OFS_STEER  = 3'h3;
	localparam logic [2:0] OFS_DEAD   = 3'h4;
	localparam logic [2:0] OFS_STATUS = 3'h5;
	localparam logic [2:0] OFS_TSEL   = 3'h6;

	localparam logic [7:0] RST_CTRL  = 8'h00;
	localparam logic [7:0] RST_DUTY  = 8'h00;
	localparam logic [7:0] RST_SHUT  = 8'h00;
	localparam logic [7:0] RST_STEER = 8'h01;
	localparam logic [7:0] RST_DEAD  = 8'h00;
	localparam logic [7:0] RST_TSEL  = 8'h00;
	localparam logic [7:0] STEER_MASK = 8'h1f;

	// status bits
	localparam int ST_PERIOD = 0;
	localparam int ST_EVENT  = 1;
	// shutdown register bits
	localparam int SH_EVENT = 7;
	// steering sync bit
	localparam int STEER_SYNC = 4;
	// dead-band register restart bit
	localparam int DEAD_RESTART = 7;

	// unit mode codes
	localparam logic [3:0] MODE_OFF    = 4'h0;
	localparam logic [3:0] MODE_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAPF   = 4'h4;
	localparam logic [3:0] MODE_CAPR   = 4'h5;
	localparam logic [3:0] MODE_CAP4   = 4'h6;
	localparam logic [3:0] MODE_CAP16  = 4'h7;
	localparam logic [3:0] MODE_SETHI  = 4'h8;
	localparam logic [3:0] MODE_SETLO  = 4'h9;
	localparam logic [3:0] MODE_SWINT  = 4'ha;
	localparam logic [3:0] MODE_SPECL  = 4'hb;

	typedef enum logic [1:0] {
		CFG_SINGLE = 2'h0,
		CFG_FWD    = 2'h1,
		CFG_HALF   = 2'h2,
		CFG_REV    = 2'h3
	} eps_cfg_type;

	// full-bridge direction swap lead, in timer counts
	localparam logic [7:0] SWAP_LEAD = 8'h04;
	localparam logic [3:0] CAP4_CNT  = 4'h3;
	localparam logic [3:0] CAP16_CNT = 4'hf;

	typedef struct packed {
		logic       periodStart;
		logic       match;
		logic [9:0] count;
		logic [7:0] period;
	} eps_timer_type;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} eps_bus_type;
endpackage

/* File: hw/eps_pwm_steer.sv */
// eps_pwm_steer: output stage, mode decode, dead band and steering of
// an enhanced capture/compare/pwm unit.
// assumes a period timer on ref_clk (40 MHz instruction clock) and
// port logic that supplies pin latches and directions.
//
// Functional notes
// (R1) half bridge: only inactive-to-active edges are delayed by dead band
// (R2) dead band is a seven-bit count of instruction cycles
// (R3) dead band longer than active time keeps output inactive all cycle
// (R4) single output with pwm mode: steer enables pick outputs a to d
// (R5) while steering, mode low bits set polarity of steered pins
// (R6) shutdown during steering touches only steered pins
// (R7) firmware sets at least one steer enable for any waveform
// (R8) sync clear: steering change applies right after its write
// (R9) sync set: steering change waits for next period start
// (R10) pwm polarity codes 1100 to 1111 set pair polarities a/c, b/d
// (R11) firmware picks polarity before enabling pin drivers
// (R12) firmware waits one full pwm cycle before enabling drivers
// (R13) period flag sets when second period after enable begins
// (R14) after reset all pins are high impedance
// (R15) output config decodes single, forward, half, reverse
// (R16) direction change: blank and swap four counts before period end
// (R17) capture/compare: a is unit pin, b to d are port pins
// (R18) duty is ten bits: low field then duty high byte
// (R19) mode 0000 turns off and resets; 0001, 0011 select nothing
// (R20) capture on falling, rising, 4th rising, 16th rising edge
// (R21) mode 0010 toggles compare pin on match
// (R22) 1000 starts low sets, 1001 starts high clears; both flag
// (R23) mode 1010 flags only, pin returns to port
// (R24) mode 1011 resets timer, flags, starts conversion if enabled
// (R25) without enhancement config bits absent, 11xx is plain pwm
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module eps_pwm_steer #(
	parameter bit ENHANCED = 1'b1
) (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               nrst,
	// register port
	input  wire eps_pkg::eps_bus_type bus,
	output logic [7:0]              rdData,
	// period timer
	input  wire eps_pkg::eps_timer_type tmr,
	output logic                    timerReset,
	// converter and pins in
	input  wire logic               adcEnabled,
	input  wire logic               capturePin,
	input  wire logic               faultPin,
	input  wire logic [3:0]         portLatch,
	input  wire logic [3:0]         pinDirection,
	// events and pins out
	output logic                    adcStart,
	output logic                    captureStrobe,
	output logic [3:0]              pinOut,
	output logic [3:0]              pinOe
);
	logic [7:0] ctrl_r, duty_r, shut_r, steer_r, dead_r, tsel_r;
	logic [1:0] status_r;
	logic [3:0] steerEff_r;
	logic [9:0] dutyLat_r;
	logic [2:0] syn0_r, syn1_r, syn2_r;
	logic       capLvl_r, faultLvl_r, shutAct_r, cmpPin_r, fbDir_r;
	logic       fbBlank_r, startSeen_r;
	logic [3:0] capCnt_r;
	logic [6:0] dbCnt_r [2];
	logic [1:0] dbOut;
	logic [3:0] mode, act, own, lvl, pol, shutMask, pinOut_nxt, pinOe_nxt;
	logic [1:0] cfg;
	logic       pwmMode, wrCtrl, capHit, capRise, capFall, nearEnd;
	logic       pwmRaw, evt, modeChg, fbMute;

	assign mode    = ctrl_r[3:0];
	assign cfg     = ENHANCED ? ctrl_r[7:6] : 2'h0; // [R25]
	assign pwmMode = mode[3:2] == 2'h3;
	assign wrCtrl  = bus.wr && bus.addr == eps_pkg::OFS_CTRL;
	assign modeChg = wrCtrl && bus.wdata[3:0] != mode;
	assign pwmRaw  = tmr.count < dutyLat_r;
	assign nearEnd = tmr.count[9:2] == tmr.period - eps_pkg::SWAP_LEAD
		&& tmr.count[1:0] == 2'h0;
	// blanking lifts in the first cycle of the new period
	assign fbMute  = fbBlank_r && !tmr.periodStart;

	// register writes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r  <= eps_pkg::RST_CTRL;
			duty_r  <= eps_pkg::RST_DUTY;
			steer_r <= eps_pkg::RST_STEER;
			dead_r  <= eps_pkg::RST_DEAD;
			tsel_r  <= eps_pkg::RST_TSEL;
		end else if (bus.wr) begin
			unique case (bus.addr)
				eps_pkg::OFS_CTRL: ctrl_r <= ENHANCED ? bus.wdata
					: {2'h0, bus.wdata[5:0]};
				eps_pkg::OFS_DUTY: duty_r <= bus.wdata;
				eps_pkg::OFS_STEER: steer_r <= bus.wdata & eps_pkg::STEER_MASK;
				eps_pkg::OFS_DEAD: dead_r <= bus.wdata;
				eps_pkg::OFS_TSEL: tsel_r <= bus.wdata;
				default: ;
			endcase
		end
	end

	// shutdown control, event bit set by fault, cleared by sw or restart
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			shut_r <= eps_pkg::RST_SHUT;
		end else begin
			if (bus.wr && bus.addr == eps_pkg::OFS_SHUT) begin
				shut_r[6:0] <= bus.wdata[6:0];
				if (!(faultLvl_r && shut_r[6:4] != 3'h0)) begin
					shut_r[eps_pkg::SH_EVENT] <= bus.wdata[eps_pkg::SH_EVENT];
				end
			end
			if (faultLvl_r && shut_r[6:4] != 3'h0) begin
				shut_r[eps_pkg::SH_EVENT] <= 1'b1;
			end else if (dead_r[eps_pkg::DEAD_RESTART] && shut_r[6:4] != 3'h0
				&& shutAct_r) begin
				shut_r[eps_pkg::SH_EVENT] <= 1'b0;
			end
		end
	end

	// shutdown state ends only at a period start once the event clears
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			shutAct_r <= 1'b0;
		end else if (shut_r[eps_pkg::SH_EVENT]) begin
			shutAct_r <= 1'b1;
		end else if (tmr.periodStart) begin
			shutAct_r <= 1'b0;
		end
	end

	// pin synchronisers: capture and fault
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			syn0_r     <= 3'h0;
			syn1_r     <= 3'h0;
			syn2_r     <= 3'h0;
			capLvl_r   <= 1'b0;
			faultLvl_r <= 1'b0;
		end else begin
			syn0_r <= {1'b0, faultPin, capturePin};
			syn1_r <= syn0_r;
			syn2_r <= syn1_r;
			if (syn1_r[0] == syn2_r[0]) begin
				capLvl_r <= syn2_r[0];
			end
			if (syn1_r[1] == syn2_r[1]) begin
				faultLvl_r <= syn2_r[1];
			end
		end
	end

	assign capRise = syn1_r[0] == syn2_r[0] && syn2_r[0] && !capLvl_r;
	assign capFall = syn1_r[0] == syn2_r[0] && !syn2_r[0] && capLvl_r;

	// capture prescaler
	always_comb begin
		capHit = 1'b0;
		unique case (mode)
			eps_pkg::MODE_CAPF: capHit = capFall; // [R20]
			eps_pkg::MODE_CAPR: capHit = capRise; // [R20]
			eps_pkg::MODE_CAP4:
				capHit = capRise && capCnt_r[1:0] == eps_pkg::CAP4_CNT[1:0]; // [R20]
			eps_pkg::MODE_CAP16:
				capHit = capRise && capCnt_r == eps_pkg::CAP16_CNT; // [R20]
			default: capHit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			capCnt_r <= 4'h0;
		end else if (modeChg || mode == eps_pkg::MODE_OFF) begin
			capCnt_r <= 4'h0; // [R19]
		end else if (capRise) begin
			capCnt_r <= capCnt_r + 4'h1;
		end
	end

	// compare pin and event pulses
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cmpPin_r      <= 1'b0;
			timerReset    <= 1'b0;
			adcStart      <= 1'b0;
			captureStrobe <= 1'b0;
		end else begin
			captureStrobe <= capHit;
			timerReset    <= mode == eps_pkg::MODE_SPECL && tmr.match; // [R24]
			adcStart      <= mode == eps_pkg::MODE_SPECL && tmr.match
				&& adcEnabled; // [R24]
			if (modeChg) begin
				cmpPin_r <= bus.wdata[3:0] == eps_pkg::MODE_SETLO; // [R22]
			end else if (tmr.match) begin
				unique case (mode)
					eps_pkg::MODE_TOGGLE: cmpPin_r <= !cmpPin_r; // [R21]
					eps_pkg::MODE_SETHI: cmpPin_r <= 1'b1; // [R22]
					eps_pkg::MODE_SETLO: cmpPin_r <= 1'b0; // [R22]
					default: ;
				endcase
			end
		end
	end

	assign evt = capHit || (tmr.match && (mode == eps_pkg::MODE_TOGGLE
		|| mode[3:2] == 2'h2)); // [R22] [R23] [R24]

	// status flags: write one to clear, set wins
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			status_r    <= 2'h0;
			startSeen_r <= 1'b0;
		end else begin
			if (!pwmMode) begin
				startSeen_r <= 1'b0;
			end else if (tmr.periodStart) begin
				startSeen_r <= 1'b1;
			end
			if (bus.wr && bus.addr == eps_pkg::OFS_STATUS) begin
				status_r <= status_r & ~bus.wdata[1:0];
			end
			if (pwmMode && tmr.periodStart && startSeen_r) begin
				status_r[eps_pkg::ST_PERIOD] <= 1'b1; // [R13]
			end
			if (evt) begin
				status_r[eps_pkg::ST_EVENT] <= 1'b1;
			end
		end
	end

	// duty latch at period start, ten bits
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dutyLat_r <= 10'h000;
		end else if (tmr.periodStart) begin
			dutyLat_r <= {duty_r, ctrl_r[5:4]}; // [R18]
		end
	end

	// steering update, immediate or period aligned
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			steerEff_r <= eps_pkg::RST_STEER[3:0];
		end else if (bus.wr && bus.addr == eps_pkg::OFS_STEER
			&& !bus.wdata[eps_pkg::STEER_SYNC]) begin
			steerEff_r <= bus.wdata[3:0]; // [R8]
		end else if (tmr.periodStart && steer_r[eps_pkg::STEER_SYNC]) begin
			steerEff_r <= steer_r[3:0]; // [R9]
		end
	end

	// full-bridge direction swap
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fbDir_r   <= 1'b0;
			fbBlank_r <= 1'b0;
		end else if (pwmMode && cfg[0] && cfg[1] != fbDir_r && nearEnd) begin
			fbDir_r   <= cfg[1]; // [R16]
			fbBlank_r <= 1'b1;
		end else if (!(pwmMode && cfg[0])) begin
			// entry into full bridge takes the written direction at once
			fbDir_r   <= (ENHANCED && wrCtrl) ? bus.wdata[7] : cfg[1];
			fbBlank_r <= 1'b0;
		end else if (tmr.periodStart) begin
			fbBlank_r <= 1'b0; // [R16]
		end
	end

	// dead band, one delay per half-bridge output
	for (genvar i = 0; i < 2; i++) begin : gDead
		logic raw;
		assign raw = (i == 0) ? pwmRaw : !pwmRaw;
		assign dbOut[i] = raw && dbCnt_r[i] == dead_r[6:0]; // [R1] [R3]
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				dbCnt_r[i] <= 7'h00;
			end else if (!raw || cfg != eps_pkg::CFG_HALF) begin
				dbCnt_r[i] <= 7'h00;
			end else if (dbCnt_r[i] != dead_r[6:0]) begin
				dbCnt_r[i] <= dbCnt_r[i] + 7'h01; // [R2]
			end
		end
	end

	// output decode
	always_comb begin
		act = 4'h0;
		own = 4'h0;
		pol = {mode[0], mode[1], mode[0], mode[1]}; // [R5] [R10]
		if (pwmMode) begin
			unique case (cfg)
				eps_pkg::CFG_SINGLE: begin
					own = ENHANCED ? steerEff_r : 4'h1; // [R4] [R15]
					act = {4{pwmRaw}};
				end
				eps_pkg::CFG_HALF: begin
					own = 4'h3; // [R15]
					act = {2'h0, dbOut};
				end
				default: begin
					own = 4'hf; // [R15]
					act = fbDir_r ? {2'h1, pwmRaw && !fbMute, 1'b0}
						: {pwmRaw && !fbMute, 3'h1}; // [R16]
				end
			endcase
			if (!ENHANCED) begin
				pol = 4'h0;
			end
		end else if (mode == eps_pkg::MODE_TOGGLE || mode == eps_pkg::MODE_SETHI
			|| mode == eps_pkg::MODE_SETLO) begin
			own = 4'h1; // [R17]
			act = {3'h0, cmpPin_r};
			pol = 4'h0;
		end
		lvl      = act ^ pol;
		shutMask = (pwmMode && shutAct_r) ? own : 4'h0; // [R6]
		for (int k = 0; k < 4; k++) begin
			if (shutMask[k]) begin
				lvl[k] = k[0] ? shut_r[0] : shut_r[2];
			end
		end
		for (int k = 0; k < 4; k++) begin
			pinOut_nxt[k] = own[k] ? lvl[k] : portLatch[k];
			pinOe_nxt[k]  = !pinDirection[k]
				&& !(shutMask[k] && (k[0] ? shut_r[1] : shut_r[3]));
		end
	end

	// pins start released
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pinOut <= 4'h0;
			pinOe  <= 4'h0; // [R14]
		end else begin
			pinOut <= pinOut_nxt;
			pinOe  <= pinOe_nxt;
		end
	end

	// read port, data in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdData <= 8'h00;
		end else if (bus.rd) begin
			unique case (bus.addr)
				eps_pkg::OFS_CTRL: rdData <= ctrl_r;
				eps_pkg::OFS_DUTY: rdData <= duty_r;
				eps_pkg::OFS_SHUT: rdData <= shut_r;
				eps_pkg::OFS_STEER: rdData <= steer_r;
				eps_pkg::OFS_DEAD: rdData <= dead_r;
				eps_pkg::OFS_STATUS: rdData <= {6'h00, status_r};
				eps_pkg::OFS_TSEL: rdData <= tsel_r;
				default: rdData <= 8'h00;
			endcase
		end else begin
			rdData <= 8'h00;
		end
	end

	// checks
	sequence sSteerWr;
		bus.wr && bus.addr == eps_pkg::OFS_STEER;
	endsequence
	a_steer_now: assert property (@(posedge ref_clk) disable iff (!nrst)
		sSteerWr ##0 !bus.wdata[4] |=> steerEff_r == $past(bus.wdata[3:0]))
		else $error("steering not immediate"); // [R8]
	a_steer_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		!tmr.periodStart && !(bus.wr && bus.addr == eps_pkg::OFS_STEER)
		|=> $stable(steerEff_r))
		else $error("steering changed off period"); // [R9]
	a_dead_delay: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(pwmRaw) ##0 (cfg == eps_pkg::CFG_HALF && pwmRaw
		&& dead_r[6:0] == 7'h03) [*4]
		|-> dbOut[0] && !$past(dbOut[0]) && !$past(dbOut[0], 2)
		&& !$past(dbOut[0], 3))
		else $error("dead band length wrong"); // [R1]
	a_dead_fall: assert property (@(posedge ref_clk) disable iff (!nrst)
		!pwmRaw |-> !dbOut[0]) else $error("falling edge delayed"); // [R1]
	a_reset_hiz: assert property (@(posedge ref_clk)
		$rose(nrst) |-> pinOe == 4'h0) else $error("pins driven at reset"); // [R14]
	a_period_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
		pwmMode && tmr.periodStart && startSeen_r |=> status_r[0])
		else $error("period flag missed"); // [R13]
	a_toggle_cmp: assert property (@(posedge ref_clk) disable iff (!nrst)
		mode == eps_pkg::MODE_TOGGLE && tmr.match && !modeChg
		|=> cmpPin_r != $past(cmpPin_r)) else $error("no toggle"); // [R21]
	a_special_ev: assert property (@(posedge ref_clk) disable iff (!nrst)
		mode == eps_pkg::MODE_SPECL && tmr.match |=> timerReset
		&& status_r[1] && adcStart == $past(adcEnabled))
		else $error("special event incomplete"); // [R24]
endmodule

/* File: testbench/eps_switch_model.sv */
// eps_switch_model: power switch drivers hung on the four pwm pins.
// assumes a pull-down on every gate input and sampling on ref_clk.
`timescale 1ns/1ps
module eps_switch_model (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// pins from the unit
	input  wire logic [3:0] pinOut,
	input  wire logic [3:0] pinOe,
	// gate levels and overlap count
	output logic [3:0]      gate,
	output logic [15:0]     overlap
);
	// an undriven gate falls to its pull-down, switch off
	assign gate = pinOe & pinOut;

	// cycles with both half-bridge switches on at once
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			overlap <= 16'h0000;
		else if (gate[0] && gate[1])
			overlap <= overlap + 16'h0001;
	end
endmodule

/* File: testbench/tb_enhanced_pwm_output_steering.sv */
// tb_enhanced_pwm_output_steering: self-checking bench of eps_pwm_steer.
// assumes eps_pkg and the switch model; the bench runs the period timer.
`timescale 1ns/1ps
module tb_enhanced_pwm_output_steering;
	localparam logic [7:0] PER  = 8'h07;
	localparam int         PLEN = (int'(PER) + 1) * 4;
	// old drive still shows in the lead point cycle itself
	localparam int         LEAD = 4 * (int'(PER) - int'(eps_pkg::SWAP_LEAD)) + 1;
	logic                  ref_clk, nrst, timerReset, adcEnabled, adcStart;
	logic                  capturePin, faultPin, captureStrobe, matchPulse;
	eps_pkg::eps_bus_type  bus;
	eps_pkg::eps_timer_type tmr;
	logic [7:0]            rdData, rv;
	logic [3:0]            portLatch, pinDirection, pinOut, pinOe, gate;
	logic [15:0]           overlap, ov0;
	logic [9:0]            cnt;
	int                    miscompares, checked, nTr, nAd, nCap;
	int                    hi [4];

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// period timer, restarted by the special event trigger
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			cnt <= 10'h000;
		else if (timerReset || cnt == {PER, 2'h3})
			cnt <= 10'h000;
		else
			cnt <= cnt + 10'h001;
	end
	assign tmr = {cnt == 10'h000, matchPulse, cnt, PER};

	eps_pwm_steer i_dut (.ref_clk(ref_clk), .nrst(nrst), .bus(bus),
		.rdData(rdData), .tmr(tmr), .timerReset(timerReset),
		.adcEnabled(adcEnabled), .capturePin(capturePin),
		.faultPin(faultPin), .portLatch(portLatch),
		.pinDirection(pinDirection), .adcStart(adcStart),
		.captureStrobe(captureStrobe), .pinOut(pinOut), .pinOe(pinOe));
	eps_switch_model i_sw (.ref_clk(ref_clk), .nrst(nrst), .pinOut(pinOut),
		.pinOe(pinOe), .gate(gate), .overlap(overlap));

	task results;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= {a, d, 2'b10};
		@(posedge ref_clk);
		bus <= '0;
	endtask

	task rd(input logic [2:0] a);
		@(posedge ref_clk);
		bus <= {a, 8'h00, 2'b01};
		@(posedge ref_clk);
		bus <= '0;
		#1 rv = rdData;
	endtask

	task waitPs;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (cnt !== 10'h000 && n < 200);
		if (n >= 200) begin
			miscompares++;
			results;
		end
	endtask

	// high cycles of each pin over one period
	task measure(input bit now);
		hi = '{0, 0, 0, 0};
		if (!now)
			waitPs;
		repeat (PLEN) begin
			@(posedge ref_clk);
			#1;
			for (int b = 0; b < 4; b++)
				hi[b] += (pinOut[b] === 1'b1);
		end
	endtask

	function automatic logic [31:0] pk;
		return {hi[3][7:0], hi[2][7:0], hi[1][7:0], hi[0][7:0]};
	endfunction

	task pulse;
		nTr = 0;
		nAd = 0;
		@(posedge ref_clk);
		matchPulse <= 1'b1;
		@(posedge ref_clk);
		matchPulse <= 1'b0;
		repeat (4) begin
			#1;
			nTr += (timerReset === 1'b1);
			nAd += (adcStart === 1'b1);
			@(posedge ref_clk);
		end
	endtask

	task capSet(input logic v);
		@(posedge ref_clk);
		capturePin <= v;
		repeat (6) begin
			#1 nCap += (captureStrobe === 1'b1);
			@(posedge ref_clk);
		end
	endtask

	task t_reset;
		logic [7:0] ex [8];
		ex = '{eps_pkg::RST_CTRL, eps_pkg::RST_DUTY, eps_pkg::RST_SHUT,
			eps_pkg::RST_STEER, eps_pkg::RST_DEAD, 8'h00,
			eps_pkg::RST_TSEL, 8'h00};
		chk("pinOe", 4'h0, pinOe);
		for (int i = 0; i < 8; i++) begin
			rd(i[2:0]);
			chk("reset value", ex[i], rv);
		end
		wr(eps_pkg::OFS_STEER, 8'hff);
		rd(eps_pkg::OFS_STEER);
		chk("steer mask", eps_pkg::STEER_MASK, rv);
		wr(3'h7, 8'hff);
		rd(3'h7);
		chk("unmapped", 8'h00, rv);
		wr(eps_pkg::OFS_STEER, eps_pkg::RST_STEER);
	endtask

	task t_start;
		wr(eps_pkg::OFS_DUTY, 8'hff);
		waitPs;
		wr(eps_pkg::OFS_CTRL, 8'h0c);
		waitPs;
		cyc(2);
		rd(eps_pkg::OFS_STATUS);
		chk("flag first", 1'b0, rv[0]);
		waitPs;
		cyc(2);
		rd(eps_pkg::OFS_STATUS);
		chk("flag second", 1'b1, rv[0]);
		wr(eps_pkg::OFS_STATUS, 8'h01);
		rd(eps_pkg::OFS_STATUS);
		chk("flag clear", 1'b0, rv[0]);
		@(posedge ref_clk);
		pinDirection <= 4'h0;
	endtask

	task t_steer;
		logic [3:0] e;
		logic [1:0] mm;
		for (int m = 0; m < 4; m++)
			for (int s = 1; s < 16; s++) begin
				mm = m[1:0];
				for (int b = 0; b < 4; b++)
					e[b] = s[b] ? ~(b[0] ? mm[0] : mm[1]) : portLatch[b];
				wr(eps_pkg::OFS_CTRL, {4'h0, 2'b11, mm});
				wr(eps_pkg::OFS_STEER, {4'h0, s[3:0]});
				cyc(2);
				chk("steered pins", e, pinOut);
			end
	endtask

	task t_sync;
		wr(eps_pkg::OFS_CTRL, 8'h0c);
		wr(eps_pkg::OFS_STEER, 8'h01);
		waitPs;
		wr(eps_pkg::OFS_STEER, 8'h18);
		cyc(2);
		chk("sync hold", {portLatch[3:1], 1'b1}, pinOut);
		waitPs;
		cyc(2);
		chk("sync apply", {1'b1, portLatch[2:0]}, pinOut);
	endtask

	task t_shut;
		@(posedge ref_clk);
		portLatch <= 4'h0;
		wr(eps_pkg::OFS_DUTY, 8'h00);
		wr(eps_pkg::OFS_STEER, 8'h05);
		wr(eps_pkg::OFS_SHUT, 8'h45);
		waitPs;
		cyc(2);
		chk("before fault", 4'h0, pinOut);
		@(posedge ref_clk);
		faultPin <= 1'b1;
		cyc(8);
		chk("fault pins", 4'h5, pinOut);
		rd(eps_pkg::OFS_SHUT);
		chk("fault event", 1'b1, rv[eps_pkg::SH_EVENT]);
		@(posedge ref_clk);
		faultPin <= 1'b0;
		cyc(4);
		wr(eps_pkg::OFS_SHUT, 8'h45);
		waitPs;
		cyc(3);
		chk("restart", 4'h0, pinOut);
	endtask

	task t_half;
		wr(eps_pkg::OFS_SHUT, 8'h00);
		wr(eps_pkg::OFS_DUTY, 8'h04);
		wr(eps_pkg::OFS_DEAD, 8'h03);
		wr(eps_pkg::OFS_CTRL, 8'h8c);
		measure(1'b0);
		ov0 = overlap;
		measure(1'b0);
		chk("half a", 16 - 3, hi[0]);
		chk("half b", PLEN - 16 - 3, hi[1]);
		chk("overlap", 16'h0000, overlap - ov0);
		wr(eps_pkg::OFS_DEAD, 8'h7f);
		measure(1'b0);
		measure(1'b0);
		chk("long dead a", 0, hi[0]);
		chk("long dead b", 0, hi[1]);
		wr(eps_pkg::OFS_DEAD, 8'h00);
		wr(eps_pkg::OFS_CTRL, 8'h9c);
		measure(1'b0);
		measure(1'b0);
		chk("ten bit duty", {8'd15, 8'd17}, {hi[1][7:0], hi[0][7:0]});
	endtask

	task t_full;
		wr(eps_pkg::OFS_CTRL, 8'h4c);
		measure(1'b0);
		measure(1'b0);
		chk("forward", {8'd16, 8'd0, 8'd0, 8'(PLEN)}, pk());
		fork
			measure(1'b1);
			wr(eps_pkg::OFS_CTRL, 8'hcc);
		join
		chk("swap", {8'(LEAD), 8'(PLEN - LEAD), 8'd0, 8'(LEAD)}, pk());
		measure(1'b1);
		chk("reverse", {8'd0, 8'(PLEN), 8'd16, 8'd0}, pk());
	endtask

	task t_cmp;
		logic [3:0] m, md [7];
		logic       a0, ea;
		md = '{4'h8, 4'h9, 4'h2, 4'ha, 4'hb, 4'h1, 4'h3};
		@(posedge ref_clk);
		portLatch <= 4'h6;
		for (int i = 0; i < 7; i++) begin
			m = md[i];
			wr(eps_pkg::OFS_CTRL, 8'h00);
			wr(eps_pkg::OFS_STATUS, 8'h03);
			wr(eps_pkg::OFS_CTRL, {4'h0, m});
			cyc(2);
			a0 = pinOut[0];
			if (m[3:1] == 3'b100)
				chk("compare start", m[0], a0);
			pulse;
			case (m)
				4'h8: ea = 1'b1;
				4'h9: ea = 1'b0;
				4'h2: ea = ~a0;
				default: ea = portLatch[0];
			endcase
			if (m != 4'hb)
				chk("pin a", ea, pinOut[0]);
			chk("port pins", portLatch[3:1], pinOut[3:1]);
			rd(eps_pkg::OFS_STATUS);
			chk("event flag", m != 4'h1 && m != 4'h3, rv[1]);
			chk("timer reset", m == 4'hb, nTr);
			chk("conversion", m == 4'hb, nAd);
		end
		wr(eps_pkg::OFS_CTRL, {4'h0, eps_pkg::MODE_SPECL});
		@(posedge ref_clk);
		adcEnabled <= 1'b0;
		pulse;
		chk("no conversion", 0, nAd);
		chk("reset without adc", 1, nTr);
		wr(eps_pkg::OFS_CTRL, 8'h00);
		cyc(2);
		chk("unit off", portLatch, pinOut);
	endtask

	task t_cap;
		int cn [4];
		cn = '{16, 16, 4, 1};
		for (int i = 0; i < 4; i++) begin
			wr(eps_pkg::OFS_CTRL, 8'h00);
			wr(eps_pkg::OFS_CTRL, 8'h04 + 8'(i));
			cyc(4);
			nCap = 0;
			repeat (16) begin
				capSet(1'b1);
				capSet(1'b0);
			end
			capSet(1'b0);
			chk("captures", cn[i], nCap);
		end
	endtask

	initial begin
		repeat (100000) @(posedge ref_clk);
		miscompares++;
		results;
	end

	initial begin
		nrst = 1'b0;
		bus = '0;
		matchPulse = 1'b0;
		adcEnabled = 1'b1;
		capturePin = 1'b0;
		faultPin = 1'b0;
		portLatch = 4'h6;
		pinDirection = 4'hf;
		miscompares = 0;
		checked = 0;
		repeat (2) @(posedge ref_clk);
		chk("pinOe in reset", 4'h0, pinOe);
		nrst <= 1'b1;
		t_reset;
		t_start;
		t_steer;
		t_sync;
		t_shut;
		t_half;
		t_full;
		t_cmp;
		t_cap;
		results;
	end
endmodule
